// file: ssr_pkg.sv
// Constants for the synchronous serial receive block
package ssr_pkg;
    // ****************************************
    // APB register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_RCV_STAT = 8'h00;
    localparam logic [7:0] ADDR_RCV_DATA = 8'h04;
    localparam logic [7:0] ADDR_TX_STAT = 8'h08;
    localparam logic [7:0] ADDR_BAUD_CTL = 8'h0C;
    localparam logic [7:0] ADDR_DIV_HI = 8'h10;
    localparam logic [7:0] ADDR_DIV_LO = 8'h14;
    localparam logic [7:0] ADDR_INT_CTL = 8'h18;

    // ****************************************
    // Receive status/control fields
    // ****************************************
    localparam int RS_PORT_EN = 7;
    localparam int RS_NINE = 6;
    localparam int RS_SINGLE = 5;
    localparam int RS_CONT = 4;
    localparam int RS_ADDR_DET = 3;
    localparam int RS_FRAME_ERR = 2;
    localparam int RS_OVERRUN = 1;
    localparam int RS_NINTH = 0;

    // ****************************************
    // Transmit status/control fields
    // ****************************************
    localparam int TS_CLK_MASTER = 7;
    localparam int TS_NINE_TX = 6;
    localparam int TS_TX_EN = 5;
    localparam int TS_SYNC = 4;
    localparam int TS_BREAK = 3;
    localparam int TS_HIGH_BAUD = 2;
    localparam int TS_SHIFT_EMPTY = 1;
    localparam int TS_TX_NINTH = 0;

    // ****************************************
    // Baud control fields
    // ****************************************
    localparam int BC_AB_OVF = 7;
    localparam int BC_RX_IDLE = 6;
    localparam int BC_DATA_POL = 5;
    localparam int BC_CLK_POL = 4;
    localparam int BC_DIV16 = 3;
    localparam int BC_UNUSED = 2;
    localparam int BC_WAKE = 1;
    localparam int BC_AUTO_BAUD = 0;

    // ****************************************
    // Interrupt control fields
    // ****************************************
    localparam int IC_RX_IE = 0;
    localparam int IC_RX_FLAG = 1;

    // ****************************************
    // Sizes and reset values
    // ****************************************
    localparam int RX_FIFO_DEPTH = 2;
    localparam int CHAR_W = 9;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// file: ssr_receiver.sv
// Synchronous serial receive path with APB register file
`timescale 1ns/1ps

// Operation
// - Two-deep FIFO, oldest character read first
// - Third character into full FIFO sets overrun
// - Overrun keeps both stored characters readable
// - No characters accepted while overrun set
// - Overrun flag read-only, cleared by actions
// - Single-receive overrun cleared by data read
// - Continuous overrun cleared by clearing continuous
// - Nine-bit select shifts nine bits per character
// - Status shows ninth bit of oldest character
// - Receive flag on completion, request if enabled
// - Status exposes overrun and ninth bit; framing bit reads zero
// - Receive status/control bit layout
// - Transmit status/control bit layout
// - Baud control bit layout, bit 2 zero
// - Sync mode without master selects slave clock
// - Slave: no receive enables means transmitter
// - Port enable bit enables the port
// - Master single receive: one character, then auto-clear
// - Continuous clocks; clearing mid-character discards
// - Sample on trailing edge, completed characters queued
// - Receive flag held while FIFO not empty
module ssr_receiver
    import ssr_pkg::*;
#(
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic SDATA_I,
    input wire logic SCLK_I,
    output logic SCLK_O,
    output logic SCLK_OE_O,
    output logic IRQ_O
);
    localparam int PTR_W = (FIFO_DEPTH > 2) ? $clog2(FIFO_DEPTH) : 1;
    localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(FIFO_DEPTH);

    // ****************************************
    // Elaboration check
    // ****************************************
    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
            $error("FIFO_DEPTH must be a power of two, at least 2");
        end
    endgenerate

    // ****************************************
    // Declarations
    // ****************************************
    logic port_en;
    logic nine_rx;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic addr_det;
    logic clock_source_master;
    logic nine_tx;
    logic tx_en;
    logic sync_mode;
    logic send_break;
    logic high_baud;
    logic transmit_ninth_bit;
    logic data_polarity_select;
    logic clock_polarity_select;
    logic sixteen_bit_divisor_select;
    logic wake_up_enable;
    logic auto_baud_enable;
    logic receive_interrupt_enable;
    logic [7:0] div_hi;
    logic [7:0] div_lo;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic data_s1;
    logic data_s2;
    logic [15:0] baud_cnt;
    logic sclk_q;
    logic [3:0] bit_cnt;
    logic [CHAR_W-1:0] shreg;
    logic [CHAR_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    logic overrun_error_flag;
    logic overrun_error_flag_cont;
    logic pready;

    // ****************************************
    // Decode
    // ****************************************
    wire acc_first = PSEL_I & PENABLE_I & ~pready;
    wire acc_done = PSEL_I & PENABLE_I & pready;
    wire wr_done = acc_done & PWRITE_I;
    wire rd_done = acc_done & ~PWRITE_I;
    wire hit_rs = PADDR_I == ADDR_RCV_STAT;
    wire hit_rd = PADDR_I == ADDR_RCV_DATA;
    wire hit_ts = PADDR_I == ADDR_TX_STAT;
    wire hit_bc = PADDR_I == ADDR_BAUD_CTL;
    wire hit_dh = PADDR_I == ADDR_DIV_HI;
    wire hit_dl = PADDR_I == ADDR_DIV_LO;
    wire hit_ic = PADDR_I == ADDR_INT_CTL;
    wire mapped = hit_rs | hit_rd | hit_ts | hit_bc | hit_dh | hit_dl | hit_ic;
    wire data_read = rd_done & hit_rd;
    wire fifo_full = count == FULL_CNT;
    wire fifo_empty = count == '0;
    wire [CHAR_W-1:0] head = fifo_mem[rd_ptr];
    wire rx_flag = ~fifo_empty;

    // ****************************************
    // Mode and clocking
    // ****************************************
    // Slave unless master source
    wire is_master = sync_mode & clock_source_master;
    wire rx_want = single_receive_enable | continuous_receive_enable;
    wire rx_on = port_en & sync_mode & rx_want & ~overrun_error_flag;
    wire master_run = rx_on & is_master;
    wire [15:0] half_limit = sixteen_bit_divisor_select ? {div_hi, div_lo} : {BYTE_ZERO, div_lo};
    wire baud_hit = baud_cnt == half_limit;
    wire master_fall = master_run & baud_hit & sclk_q;
    wire slave_fall = ~is_master & sclk_s3 & ~sclk_s2;
    wire sample = rx_on & (is_master ? master_fall : slave_fall);
    wire [3:0] last_idx = nine_rx ? LAST_BIT_9 : LAST_BIT_8;
    wire char_done = sample & (bit_cnt == last_idx);
    wire [CHAR_W-1:0] next_word = shreg | ({{(CHAR_W-1){1'b0}}, data_s2} << bit_cnt);
    wire push = char_done & ~fifo_full;
    wire overrun_evt = char_done & fifo_full;
    wire pop = data_read & ~fifo_empty;
    wire clr_single = ~overrun_error_flag_cont & data_read;
    wire clr_cont = overrun_error_flag_cont & ~continuous_receive_enable;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            data_s1 <= 1'b0;
            data_s2 <= 1'b0;
        end else begin
            sclk_s1 <= SCLK_I;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            data_s1 <= SDATA_I;
            data_s2 <= data_s1;
        end
    end

    // ****************************************
    // Master clock generator
    // ****************************************
    // Clock stops when enables drop
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            baud_cnt <= '0;
            sclk_q <= 1'b0;
        end else if (!master_run) begin
            baud_cnt <= '0;
            sclk_q <= 1'b0;
        end else if (baud_hit) begin
            baud_cnt <= '0;
            sclk_q <= ~sclk_q;
        end else begin
            baud_cnt <= baud_cnt + 16'h0001;
        end
    end

    // ****************************************
    // Receive shift register
    // ****************************************
    // Partial character discarded
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            bit_cnt <= '0;
            shreg <= '0;
        end else if (!rx_on || char_done) begin
            bit_cnt <= '0;
            shreg <= '0;
        end else if (sample) begin
            bit_cnt <= bit_cnt + 4'h1;
            shreg <= next_word;
        end
    end

    // ****************************************
    // Receive FIFO
    // ****************************************
    always_ff @(posedge CLOCK_I) begin
        if (push) begin
            fifo_mem[wr_ptr] <= next_word;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (!port_en) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
        end
    end

    // ****************************************
    // Overrun flag
    // ****************************************
    // Only clearing actions and port disable drop it
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            overrun_error_flag <= 1'b0;
            overrun_error_flag_cont <= 1'b0;
        end else if (!port_en) begin
            overrun_error_flag <= 1'b0;
            overrun_error_flag_cont <= 1'b0;
        end else if (overrun_evt) begin
            overrun_error_flag <= 1'b1;
            overrun_error_flag_cont <= continuous_receive_enable;
        end else if (clr_single || clr_cont) begin
            overrun_error_flag <= 1'b0;
        end
    end

    // ****************************************
    // Receive status/control register
    // ****************************************
    // Port enable and receive controls
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            port_en <= 1'b0;
            nine_rx <= 1'b0;
            single_receive_enable <= 1'b0;
            continuous_receive_enable <= 1'b0;
            addr_det <= 1'b0;
        end else if (wr_done && hit_rs) begin
            port_en <= PWDATA_I[RS_PORT_EN];
            nine_rx <= PWDATA_I[RS_NINE];
            single_receive_enable <= PWDATA_I[RS_SINGLE];
            continuous_receive_enable <= PWDATA_I[RS_CONT];
            addr_det <= PWDATA_I[RS_ADDR_DET];
        end else if (char_done && is_master) begin
            single_receive_enable <= 1'b0;
        end
    end

    // ****************************************
    // Transmit status/control register
    // ****************************************
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            clock_source_master <= 1'b0;
            nine_tx <= 1'b0;
            tx_en <= 1'b0;
            sync_mode <= 1'b0;
            send_break <= 1'b0;
            high_baud <= 1'b0;
            transmit_ninth_bit <= 1'b0;
        end else if (wr_done && hit_ts) begin
            clock_source_master <= PWDATA_I[TS_CLK_MASTER];
            nine_tx <= PWDATA_I[TS_NINE_TX];
            tx_en <= PWDATA_I[TS_TX_EN];
            sync_mode <= PWDATA_I[TS_SYNC];
            send_break <= PWDATA_I[TS_BREAK];
            high_baud <= PWDATA_I[TS_HIGH_BAUD];
            transmit_ninth_bit <= PWDATA_I[TS_TX_NINTH];
        end
    end

    // ****************************************
    // Baud control, divisor, interrupt enable
    // ****************************************
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            data_polarity_select <= 1'b0;
            clock_polarity_select <= 1'b0;
            sixteen_bit_divisor_select <= 1'b0;
            wake_up_enable <= 1'b0;
            auto_baud_enable <= 1'b0;
        end else if (wr_done && hit_bc) begin
            data_polarity_select <= PWDATA_I[BC_DATA_POL];
            clock_polarity_select <= PWDATA_I[BC_CLK_POL];
            sixteen_bit_divisor_select <= PWDATA_I[BC_DIV16];
            wake_up_enable <= PWDATA_I[BC_WAKE];
            auto_baud_enable <= PWDATA_I[BC_AUTO_BAUD];
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            div_hi <= DIV_RESET;
            div_lo <= DIV_RESET;
            receive_interrupt_enable <= 1'b0;
        end else if (wr_done) begin
            if (hit_dh) begin
                div_hi <= PWDATA_I[7:0];
            end
            if (hit_dl) begin
                div_lo <= PWDATA_I[7:0];
            end
            if (hit_ic) begin
                receive_interrupt_enable <= PWDATA_I[IC_RX_IE];
            end
        end
    end

    // ****************************************
    // Read views
    // ****************************************
    // Receive status layout, bit 7 first
    // Framing error reads zero beside overrun
    wire ninth_out = head[CHAR_W-1] & ~fifo_empty;
    wire [7:0] rs_byte = {port_en, nine_rx, single_receive_enable, continuous_receive_enable, addr_det, 1'b0, overrun_error_flag, ninth_out};
    // Transmit status layout, bit 7 first
    wire [7:0] ts_byte = {clock_source_master, nine_tx, tx_en, sync_mode, send_break, high_baud, 1'b1, transmit_ninth_bit};
    // Baud control layout, bit 7 first
    wire rx_idle = bit_cnt == 4'h0;
    wire [7:0] bc_byte = {1'b0, rx_idle, data_polarity_select, clock_polarity_select, sixteen_bit_divisor_select, 1'b0, wake_up_enable, auto_baud_enable};
    wire [7:0] ic_byte = {6'h00, rx_flag, receive_interrupt_enable};

    wire [7:0] rd_mux = hit_rs ? rs_byte :
                        hit_rd ? (fifo_empty ? BYTE_ZERO : head[7:0]) :
                        hit_ts ? ts_byte :
                        hit_bc ? bc_byte :
                        hit_dh ? div_hi :
                        hit_dl ? div_lo :
                        hit_ic ? ic_byte : BYTE_ZERO;

    // ****************************************
    // APB answer and pin outputs
    // ****************************************
    // One wait state: data latched on first access cycle
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pready <= 1'b0;
            PRDATA_O <= '0;
            PSLVERR_O <= 1'b0;
        end else begin
            pready <= acc_first;
            PSLVERR_O <= acc_first & ~mapped;
            if (acc_first) begin
                PRDATA_O <= {24'h000000, rd_mux};
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            SCLK_O <= 1'b0;
            SCLK_OE_O <= 1'b0;
            IRQ_O <= 1'b0;
        end else begin
            // Clock output and its driver enable fall together
            SCLK_O <= sclk_q & port_en & is_master;
            SCLK_OE_O <= port_en & is_master;
            IRQ_O <= rx_flag & receive_interrupt_enable;
        end
    end

    assign PREADY_O = pready;
endmodule

// file: ssr_rx_props.sv
// Port checker for the synchronous serial receive block
`timescale 1ns/1ps
module ssr_rx_props
    import ssr_pkg::*;
#(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic SDATA_I,
    input wire logic SCLK_I,
    input wire logic SCLK_O,
    input wire logic SCLK_OE_O,
    input wire logic IRQ_O
);
    // ****************************************
    // Bus and pin relations
    // ****************************************
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);
    a_ready_wait: assert property ((PSEL_I && PENABLE_I && !PREADY_O) |=> PREADY_O)
        else $error("ready late after access");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (PSLVERR_O |-> PREADY_O && PSEL_I)
        else $error("error without ready");
    a_err_unmapped: assert property (PREADY_O && PADDR_I > ADDR_INT_CTL |-> PSLVERR_O)
        else $error("unmapped access not flagged");
    a_mapped_ok: assert property (PREADY_O && PADDR_I <= ADDR_INT_CTL |-> !PSLVERR_O)
        else $error("mapped access flagged");
    a_rdata_hold: assert property (!PREADY_O |-> $stable(PRDATA_O) && PRDATA_O[31:8] == 24'h0)
        else $error("read data moved between reads");
    a_irq_fall: assert property ($fell(IRQ_O) |-> $past(PREADY_O)
        || $past(PREADY_O, 2) || $past(PREADY_O, 3))
        else $error("request dropped without register access");
    a_clk_master: assert property ($rose(SCLK_O) |-> SCLK_OE_O)
        else $error("clock toggles while not master");
    a_clk_quiet: assert property (!SCLK_OE_O |-> !SCLK_O)
        else $error("clock high with driver off");
endmodule

// file: ssr_far_node.sv
// Far serial node: slave clock source and data driver
`timescale 1ns/1ps
module ssr_far_node (
    input wire logic clk_i,
    input wire logic sclk_m_i,
    output logic sclk_o,
    output logic sdata_o
);
    logic busy = 1'b0;
    logic mact = 1'b0;
    logic [8:0] mchar = 9'h000;
    int midx = 0;
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
    end
    // Data line changes every cycle outside send frames, and never again once the first mload has run
    always @(posedge clk_i) begin
        if (!busy && !mact) begin
            sdata_o <= ~sdata_o;
        end
    end
    // Next bit at the master's leading edge, settled by trailing edge
    always @(posedge sclk_m_i) begin
        if (mact) begin
            sdata_o <= (midx < 8) ? mchar[midx] : ~sdata_o;
            midx <= midx + 1;
        end
    end
    // Bits change with the rising clock edge, held past the falling edge
    task automatic send(input logic [8:0] ch, input int nb);
        busy = 1'b1;
        for (int i = 0; i < nb; i++) begin
            @(posedge clk_i);
            sdata_o <= ch[i];
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        @(posedge clk_i);
        busy = 1'b0;
    endtask
    task automatic mload(input logic [8:0] ch);
        mchar = ch;
        midx = 0;
        mact = 1'b1;
    endtask
endmodule

// file: ssr_receiver_tb.sv
// Self-checking bench for the synchronous serial receive block
`timescale 1ns/1ps
module ssr_receiver_tb
    import ssr_pkg::*;
;
    typedef struct {logic [31:0] v; logic [31:0] m; string n;} ssr_note_t;
    ssr_note_t notes[$];
    ssr_note_t nt;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic prdy, perr, sclk, sdata, sclk_m, sclk_oe, irq;
    logic [8:0] ch [8];
    int seed, err_count = 0, cmp_count = 0;
    always #12.5 clk = ~clk;
    ssr_receiver i_dut (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(prdy), .PSLVERR_O(perr), .SDATA_I(sdata), .SCLK_I(sclk),
        .SCLK_O(sclk_m), .SCLK_OE_O(sclk_oe), .IRQ_O(irq));
    ssr_far_node i_far (.clk_i(clk), .sclk_m_i(sclk_m), .sclk_o(sclk), .sdata_o(sdata));
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            give_verdict();
        end
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, string n);
        notes.push_back('{{24'h0, e}, {24'hFFFFFF, m}, n});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_bits;
        int n;
        n = 0;
        while (i_far.midx < 8 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            err_count++;
            give_verdict();
        end
        repeat (16) @(posedge clk);
    endtask
    // ****************************************
    // Read answers checked against the oldest note
    // ****************************************
    always @(posedge clk) begin
        if (psel && pen && prdy === 1'b1 && !pwr) begin
            nt = notes.pop_front();
            check(nt.n, prdata & nt.m, nt.v & nt.m);
        end
    end
    initial begin
        seed = 32'h3F08;
        for (int i = 0; i < 8; i++)
            ch[i] = $random(seed);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_RCV_STAT, 8'h00, 8'hFF, "rcv_stat reset");
        rd(ADDR_TX_STAT, 8'h02, 8'hFF, "tx_stat reset");
        wr(ADDR_BAUD_CTL, 8'hFF);
        rd(ADDR_BAUD_CTL, 8'h7B, 8'hFF, "baud_ctl");
        wr(ADDR_DIV_HI, 8'hA5);
        rd(ADDR_DIV_HI, 8'hA5, 8'hFF, "div_hi");
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'h00, 8'hFF, "unmapped");
        wr(ADDR_BAUD_CTL, 8'h00);
        wr(ADDR_TX_STAT, 8'h10);
        rd(ADDR_TX_STAT, 8'h12, 8'hFF, "tx_stat sync");
        wr(ADDR_INT_CTL, 8'h01);
        wr(ADDR_RCV_STAT, 8'h90);
        for (int k = 0; k < 4; k++) begin
            i_far.send(ch[k], 8);
            repeat (4) @(posedge clk);
            if (k == 1) begin
                rd(ADDR_INT_CTL, 8'h03, 8'hFF, "int_ctl two held");
                check("irq raised", {31'h0, irq}, 32'h1);
            end
        end
        rd(ADDR_RCV_STAT, 8'h92, 8'hFF, "overrun set");
        rd(ADDR_RCV_DATA, ch[0][7:0], 8'hFF, "first char");
        rd(ADDR_RCV_STAT, 8'h92, 8'hFF, "overrun kept");
        rd(ADDR_RCV_DATA, ch[1][7:0], 8'hFF, "second char");
        rd(ADDR_INT_CTL, 8'h01, 8'hFF, "int_ctl empty");
        wr(ADDR_RCV_STAT, 8'h90);
        rd(ADDR_RCV_STAT, 8'h92, 8'hFF, "overrun not writable");
        wr(ADDR_RCV_STAT, 8'h80);
        rd(ADDR_RCV_STAT, 8'h80, 8'hFF, "overrun cleared");
        wr(ADDR_RCV_STAT, 8'h90);
        i_far.send(ch[4], 8);
        repeat (4) @(posedge clk);
        wr(ADDR_INT_CTL, 8'h00);
        rd(ADDR_INT_CTL, 8'h02, 8'hFF, "flag masked");
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(ADDR_RCV_DATA, ch[4][7:0], 8'hFF, "after overrun");
        wr(ADDR_RCV_STAT, 8'hD0);
        i_far.send(ch[5] | 9'h100, 9);
        i_far.send(ch[6] & 9'h0FF, 9);
        repeat (4) @(posedge clk);
        rd(ADDR_RCV_STAT, 8'hD1, 8'hFF, "ninth set");
        rd(ADDR_RCV_DATA, ch[5][7:0], 8'hFF, "nine low a");
        rd(ADDR_RCV_STAT, 8'hD0, 8'hFF, "ninth clear");
        rd(ADDR_RCV_DATA, ch[6][7:0], 8'hFF, "nine low b");
        i_far.send(ch[7], 9);
        repeat (4) @(posedge clk);
        wr(ADDR_RCV_STAT, 8'h00);
        rd(ADDR_INT_CTL, 8'h00, 8'hFF, "port off empties");
        wr(ADDR_RCV_STAT, 8'h80);
        i_far.send(ch[0], 8);
        repeat (4) @(posedge clk);
        rd(ADDR_INT_CTL, 8'h00, 8'hFF, "slave transmit mode");
        wr(ADDR_DIV_LO, 8'h03);
        rd(ADDR_DIV_LO, 8'h03, 8'hFF, "div_lo");
        wr(ADDR_TX_STAT, 8'h90);
        for (int k = 0; k < 3; k++) begin
            i_far.mload(ch[k]);
            wr(ADDR_RCV_STAT, 8'hA0);
            wait_bits();
            if (k == 0)
                rd(ADDR_RCV_STAT, 8'h80, 8'hFF, "single auto clear");
        end
        rd(ADDR_RCV_STAT, 8'h82, 8'hDF, "master overrun");
        rd(ADDR_RCV_DATA, ch[0][7:0], 8'hFF, "master first");
        wr(ADDR_RCV_STAT, 8'h80);
        rd(ADDR_RCV_STAT, 8'h80, 8'h83, "read clears overrun");
        rd(ADDR_RCV_DATA, ch[1][7:0], 8'hFF, "master second");
        i_far.mload(ch[3]);
        wr(ADDR_RCV_STAT, 8'h90);
        repeat (30) @(posedge clk);
        check("clock driver on", {31'h0, sclk_oe}, 32'h1);
        wr(ADDR_RCV_STAT, 8'h80);
        rd(ADDR_BAUD_CTL, 8'h40, 8'hFF, "partial discarded");
        check("clock stopped", {31'h0, sclk_m}, 32'h0);
        rd(ADDR_INT_CTL, 8'h00, 8'hFF, "nothing queued");
        give_verdict();
    end
endmodule
bind ssr_receiver ssr_rx_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (.CLOCK_I(CLOCK_I),
    .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .SDATA_I(SDATA_I), .SCLK_I(SCLK_I), .SCLK_O(SCLK_O),
    .SCLK_OE_O(SCLK_OE_O), .IRQ_O(IRQ_O));
